//--- include/sadc_cfg.svh
// constants for the sampling converter sequencer
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

`define SADC_DATA_W     12
`define SADC_SIGN_BIT   11
`define SADC_MOST_NEG   12'h800
`define SADC_MOST_POS   12'h7FF
`define SADC_CLK_NS     8
`define SADC_CONV_NS    150
`define SADC_CONV_CYC   ((`SADC_CONV_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_CNT_W      5

`endif

//--- include/sadc_pkg.sv
// types shared by the sampling converter sequencer
`include "sadc_cfg.svh"

package sadc_pkg;

    typedef struct packed {
        logic                      out_of_range_flag;
        logic [`SADC_DATA_W-1:0]   data;
    } sadc_word_type;

    typedef enum logic [0:0] {
        SADC_IDLE,
        SADC_CONVERT
    } sadc_state_type;

endpackage

//--- rtl/sadc_stage.sv
// one pipeline stage holding a result word and its range flag
`timescale 1ns/100ps
`default_nettype none
`include "sadc_cfg.svh"

module sadc_stage (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   srst,
    // load side
    input  wire logic                   load,
    input  wire logic [`SADC_DATA_W-1:0] data_in,
    // held word
    output sadc_pkg::sadc_word_type     word_out
);

    sadc_pkg::sadc_word_type word_reg;
    sadc_pkg::sadc_word_type word_next;

    always_comb begin
        word_next = word_reg;
        if (load) begin
            word_next.data              = data_in;
            word_next.out_of_range_flag = (data_in == `SADC_MOST_NEG) ||
                                          (data_in == `SADC_MOST_POS);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            word_reg <= '0;
        end else begin
            word_reg <= word_next;
        end
    end

    assign word_out = word_reg;

    chk_flag_matches_code: assert property (@(posedge clock) disable iff (srst)
        word_out.out_of_range_flag == ((word_out.data == `SADC_MOST_NEG) || (word_out.data == `SADC_MOST_POS)))
        else $error("range flag does not match the held code");

endmodule
`default_nettype wire

//--- rtl/sadc_top.sv
// conversion sequencer and output pipeline of a 12-bit sampling converter
//
// Overview of operation
// - each sample clock rise while idle samples, starts conversion
// - edges during a conversion are ignored
// - output word updates at conversion end
// - result appears two conversions later plus conversion
// - only rising sample clock edges matter
// - results are two's complement codes
// - range flag high at both extreme codes
`timescale 1ns/100ps
`default_nettype none
`include "sadc_cfg.svh"

module sadc_top (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    srst,
    // converter pins
    input  wire logic                    sample_clk,
    input  wire logic [`SADC_DATA_W-1:0] analog_code,
    // result word
    output sadc_pkg::sadc_word_type      result_word,
    output logic                         result_sign_bit,
    output var logic                     word_update,
    // status
    output logic                         conv_busy,
    output var logic                     edge_ignored
);

    localparam int CONV_INT = `SADC_CONV_CYC;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic                    sclk_meta_reg;
    logic                    sclk_sync_reg;
    logic                    sclk_prev_reg;
    logic [`SADC_DATA_W-1:0] code_meta_reg;
    logic [`SADC_DATA_W-1:0] code_sync_reg;
    logic                    rise;

    // code bus is assumed settled around the sampling edge; no word coherence logic
    always_ff @(posedge clock) begin
        if (srst) begin
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            code_meta_reg <= '0;
            code_sync_reg <= '0;
        end else begin
            sclk_meta_reg <= sample_clk;
            sclk_sync_reg <= sclk_meta_reg;
            sclk_prev_reg <= sclk_sync_reg;
            code_meta_reg <= analog_code;
            code_sync_reg <= code_meta_reg;
        end
    end

    // falling edges carry no meaning, so duty cycle is free
    assign rise = sclk_sync_reg & ~sclk_prev_reg;

    // ************************************************************
    // conversion sequencer
    // ************************************************************
    sadc_pkg::sadc_state_type state_reg;
    sadc_pkg::sadc_state_type state_next;
    logic [`SADC_CNT_W-1:0]  cnt_reg;
    logic [`SADC_CNT_W-1:0]  cnt_next;
    logic [`SADC_DATA_W-1:0] sample_reg;
    logic [`SADC_DATA_W-1:0] sample_next;
    logic                    conv_done;
    logic                    update_next;
    logic                    ignored_next;

    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        sample_next  = sample_reg;
        conv_done    = 1'b0;
        ignored_next = 1'b0;
        unique case (state_reg)
            sadc_pkg::SADC_IDLE: begin
                if (rise) begin
                    state_next  = sadc_pkg::SADC_CONVERT;
                    sample_next = code_sync_reg;
                    cnt_next    = `SADC_CNT_W'(`SADC_CONV_CYC - 1);
                end
            end
            sadc_pkg::SADC_CONVERT: begin
                // an edge here is flagged and ignored; the conversion in flight continues
                ignored_next = rise;
                if (cnt_reg == '0) begin
                    conv_done  = 1'b1;
                    state_next = sadc_pkg::SADC_IDLE;
                end else begin
                    cnt_next = cnt_reg - `SADC_CNT_W'(1);
                end
            end
        endcase
        update_next = conv_done;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg    <= sadc_pkg::SADC_IDLE;
            cnt_reg      <= '0;
            sample_reg   <= '0;
            word_update  <= 1'b0;
            edge_ignored <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            sample_reg   <= sample_next;
            word_update  <= update_next;
            edge_ignored <= ignored_next;
        end
    end

    assign conv_busy = (state_reg == sadc_pkg::SADC_CONVERT);

    // ************************************************************
    // output pipeline
    // ************************************************************
    sadc_pkg::sadc_word_type first_word;
    sadc_pkg::sadc_word_type second_word;

    // three stages behind the converter give the two-period latency
    sadc_stage u_stage_first (
        .clock    (clock),
        .srst     (srst),
        .load     (conv_done),
        .data_in  (sample_reg),
        .word_out (first_word)
    );

    sadc_stage u_stage_second (
        .clock    (clock),
        .srst     (srst),
        .load     (conv_done),
        .data_in  (first_word.data),
        .word_out (second_word)
    );

    sadc_stage u_stage_out (
        .clock    (clock),
        .srst     (srst),
        .load     (conv_done),
        .data_in  (second_word.data),
        .word_out (result_word)
    );

    assign result_sign_bit = result_word.data[`SADC_SIGN_BIT];

    // ************************************************************
    // checks
    // ************************************************************
    sequence conv_start_s;
        rise && (state_reg == sadc_pkg::SADC_IDLE);
    endsequence

    sequence conv_end_s;
        (state_reg == sadc_pkg::SADC_CONVERT) && (cnt_reg == '0);
    endsequence

    chk_start_on_rise: assert property (@(posedge clock) disable iff (srst)
        conv_start_s |=> conv_busy && (sample_reg == $past(code_sync_reg)))
        else $error("conversion did not start on a sample clock rise");

    chk_conv_length: assert property (@(posedge clock) disable iff (srst)
        conv_start_s |-> ##[CONV_INT:CONV_INT] conv_end_s ##1 word_update)
        else $error("conversion did not end after the conversion time");

    chk_no_restart: assert property (@(posedge clock) disable iff (srst)
        conv_busy && (cnt_reg != '0) |=> conv_busy && (cnt_reg == $past(cnt_reg) - `SADC_CNT_W'(1)))
        else $error("conversion aborted or restarted in flight");

    chk_ignore_flag: assert property (@(posedge clock) disable iff (srst)
        rise && conv_busy |=> edge_ignored && $stable(sample_reg))
        else $error("edge during conversion was not ignored");

    chk_rise_only: assert property (@(posedge clock) disable iff (srst)
        !conv_busy && !rise |=> !conv_busy)
        else $error("conversion started without a rising edge");

    chk_pipe_depth: assert property (@(posedge clock) disable iff (srst)
        conv_done |=> (result_word.data == $past(second_word.data)) && (second_word.data == $past(first_word.data)))
        else $error("pipeline did not advance one stage per conversion");

    chk_code_pass: assert property (@(posedge clock) disable iff (srst)
        conv_done |=> first_word.data == $past(sample_reg))
        else $error("converted code altered on its way into the pipeline");

    chk_hold_stable: assert property (@(posedge clock) disable iff (srst)
        !conv_done |=> $stable(result_word) && !word_update)
        else $error("output word changed between updates");

endmodule
`default_nettype wire

//--- dv/sadc_capture_model.sv
// capture logic model that latches the converter word on sample clock rises
`timescale 1ns/100ps
`default_nettype none

module sadc_capture_model (
    // converter side
    input  wire logic                    sample_clk,
    input  wire sadc_pkg::sadc_word_type result_word,
    // latched word
    output var sadc_pkg::sadc_word_type  captured
);
    // latches on every rise; the falling edge carries no meaning, so any duty cycle works
    always @(posedge sample_clk) captured <= result_word;
endmodule

`default_nettype wire

//--- dv/tb.sv
// self-checking testbench for the sampling converter sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sadc_cfg.svh"

module tb;
    logic                    clock;
    logic                    srst;
    logic                    sample_clk;
    logic [`SADC_DATA_W-1:0] analog_code;
    sadc_pkg::sadc_word_type result_word;
    sadc_pkg::sadc_word_type captured;
    logic                    result_sign_bit;
    logic                    word_update;
    logic                    conv_busy;
    logic                    edge_ignored;
    int                      failures;
    int                      total_checks;
    int                      n_upd;
    int                      n_ign;
    time                     t_rise;
    logic [11:0]             hist[$];

    sadc_top uut (.clock(clock), .srst(srst), .sample_clk(sample_clk), .analog_code(analog_code),
        .result_word(result_word), .result_sign_bit(result_sign_bit), .word_update(word_update),
        .conv_busy(conv_busy), .edge_ignored(edge_ignored));
    sadc_capture_model cap (.sample_clk(sample_clk), .result_word(result_word), .captured(captured));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // sampled mid-cycle so the registered pulses are settled
    always @(negedge clock) begin
        if (word_update === 1'b1) n_upd++;
        if (edge_ignored === 1'b1) n_ign++;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [12:0] exp_w(input logic [11:0] c);
        return {(c == 12'h800) || (c == 12'h7FF), c};
    endfunction

    task automatic cmp(input string name, input logic [12:0] exp, input logic [12:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    // one accepted sampling rise; the capture at this rise holds the sample three rises back
    task automatic rise(input logic [11:0] c, input int hi);
        @(negedge clock);
        analog_code = c;
        sample_clk = 1'b1;
        t_rise = $time;
        hist.push_back(c);
        @(posedge clock);
        #1;
        if (hist.size() > 3) begin
            cmp("captured", exp_w(hist[hist.size()-4]), captured);
            cmp("sign_bit", {12'h000, hist[hist.size()-4][11]}, {12'h000, result_sign_bit});
        end
        repeat (hi) @(negedge clock);
        sample_clk = 1'b0;
    endtask

    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_pipeline;
        logic [11:0] codes[11] = '{12'h800, 12'h7FF, 12'h000, 12'hFFF, 12'h7FE, 12'h801,
                                   12'h123, 12'hABC, 12'h000, 12'h000, 12'h000};
        int u;
        u = n_upd;
        // high time swept from 2 to 22 clocks
        for (int i = 0; i < 11; i++) begin
            rise(codes[i], 2 + 2 * i);
            idle(30 - 2 * i);
        end
        cmp("updates", 13'(u + 11), 13'(n_upd));
        $display("test pipeline done");
    endtask

    task automatic test_ignored;
        int u;
        int g;
        u = n_upd;
        g = n_ign;
        rise(12'h321, 2);
        idle(6);
        cmp("busy", 13'h1, {12'h000, conv_busy});
        @(negedge clock);
        analog_code = 12'h654;
        sample_clk = 1'b1;
        idle(3);
        sample_clk = 1'b0;
        idle(30);
        cmp("ignored", 13'(g + 1), 13'(n_ign));
        cmp("no_restart", 13'(u + 1), 13'(n_upd));
        $display("test ignored done");
    endtask

    task automatic test_latency;
        int n;
        int lat;
        sadc_pkg::sadc_word_type w;
        n = 0;
        rise(12'h456, 2);
        while (word_update !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        lat = int'(($time - t_rise) / `SADC_CLK_NS);
        cmp("latency_ok", 13'h1, {12'h000, (lat >= 20 && lat <= 24)});
        w = result_word;
        idle(8);
        cmp("word_held", w, result_word);
        cmp("upd_pulse", 13'h0, {12'h000, word_update});
        idle(20);
        $display("test latency done");
    endtask

    // three plain rises push the last samples out to the capture side
    task automatic test_drain;
        for (int i = 0; i < 3; i++) begin
            rise(12'h000, 4);
            idle(27);
        end
        $display("test drain done");
    endtask

    // reset in mid-conversion: no late update, pipeline cleared, restart clean
    task automatic test_reset;
        int u;
        u = n_upd;
        rise(12'h5A5, 2);
        idle(8);
        srst = 1'b1;
        idle(2);
        srst = 1'b0;
        idle(2);
        cmp("rst_busy", 13'h0, {12'h000, conv_busy});
        cmp("rst_word", 13'h0, result_word);
        idle(30);
        cmp("rst_no_upd", 13'(u), 13'(n_upd));
        // samples taken before the reset never reach the output
        hist.delete();
        rise(12'h7FF, 2);
        idle(30);
        cmp("rst_restart", 13'(u + 1), 13'(n_upd));
        cmp("rst_word2", 13'h0, result_word);
        $display("test reset done");
    endtask

    initial begin
        srst = 1'b1;
        sample_clk = 1'b0;
        analog_code = 12'h000;
        idle(3);
        srst = 1'b0;
        idle(2);
        cmp("reset_word", 13'h0, result_word);
        test_pipeline();
        test_ignored();
        test_latency();
        test_drain();
        test_reset();
        conclude();
    end

    // the tests need under 1000 clocks
    initial begin
        #100000;
        failures++;
        conclude();
    end
endmodule

`default_nettype wire
